/* File: logic/arx_pkg.sv */
// package: constants and types for the async receive clock/data recovery block
package arx_pkg;
    localparam logic [1:0] ARX_MODE_NORMAL = 2'h0;
    localparam logic [1:0] ARX_MODE_DOUBLE = 2'h1;
    localparam int ARX_SPB_NORMAL = 16;
    localparam int ARX_SPB_DOUBLE = 8;
    localparam int ARX_SF_NORMAL = 8;
    localparam int ARX_SF_DOUBLE = 4;
    localparam int ARX_DBITS_MIN = 5;
    localparam int ARX_DBITS_MAX = 10;
    localparam int ARX_CNT_W = 5;
    localparam int ARX_SYNC_STAGES = 2;
    localparam logic ARX_LINE_IDLE = 1'b1;
    typedef enum logic [1:0] {ARX_IDLE, ARX_START, ARX_DATA, ARX_STOP} arx_state_e;
endpackage : arx_pkg

/* File: logic/arx_sample_if.sv */
// interface: synchronised line and sample tick passed to the voter
`timescale 1ns/1ps
`default_nettype none
interface arx_sample_if;
    logic line;
    logic tick;
    logic clr;
    logic [2:0] votes;
    logic level;
    modport src (output line, output tick, output clr, input votes, input level);
    modport voter (input line, input tick, input clr, output votes, output level);
endinterface : arx_sample_if
`default_nettype wire

/* File: logic/arx_voter.sv */
// module: three-sample majority voter
`timescale 1ns/1ps
`default_nettype none
module arx_voter
    import arx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // sample path
    arx_sample_if.voter sif
);
    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj3

    logic [2:0] votes_q;

    always_ff @(posedge clk) begin
        if (rst || sif.clr) begin
            votes_q <= 3'h0;
        end else if (sif.tick) begin
            votes_q <= {votes_q[1:0], sif.line};
        end
    end

    assign sif.votes = votes_q;
    assign sif.level = maj3(votes_q);
endmodule : arx_voter
`default_nettype wire

/* File: logic/arx_rx_recovery.sv */
// module: async receive start detection, clock and data recovery
//
// Overview of operation
// - Speed select 0x00 gives normal speed, 0x01 gives double speed.
// - Normal speed takes 16 samples per bit.
// - Double speed takes 8 samples per bit for start and data.
// - Double speed doubles effective baud for the same tick rate.
// - Any low sample in idle starts detection, edge or held low; first low sample is sample 1.
// - Start validated on samples 8,9,10 normal or 4,5,6 double.
// - Two or three low votes accept start and begin data recovery.
// - Fewer than two low votes reject start; no frame recovered.
// - Each data and parity bit decided by majority of three centre samples.
// - Vote samples start at 8 (middle 9) normal, 4 (middle 5) double.
// - Only first stop bit sampled; further stop bits ignored.
// - Low voted first stop bit sets frame error.
// - Ready for next start right after the stop-bit vote samples.
// - Normal mode tolerates 95.36 to 104.58 percent for D=8.
// - Double mode tolerates 96.00 to 103.90 percent for D=8.
`timescale 1ns/1ps
`default_nettype none
module arx_rx_recovery
    import arx_pkg::*;
#(
    parameter int DBITS = 9
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // configuration
    input wire logic RX_ENABLE,
    input wire logic [1:0] RECEIVE_SPEED_SELECT,
    input wire logic [3:0] FRAME_BITS,
    input wire logic SAMPLE_TICK,
    // line
    input wire logic RXD,
    // received frame
    output logic [DBITS-1:0] RX_DATA,
    output logic RX_VALID,
    output logic FRAME_ERROR,
    output logic START_REJECT,
    output logic RX_BUSY
);
    initial begin
        if (DBITS < ARX_DBITS_MIN || DBITS > ARX_DBITS_MAX) begin
            $error("DBITS out of range");
        end
    end

    localparam logic [ARX_CNT_W-1:0] SF_N = ARX_CNT_W'(ARX_SF_NORMAL);
    localparam logic [ARX_CNT_W-1:0] SF_D = ARX_CNT_W'(ARX_SF_DOUBLE);
    localparam logic [ARX_CNT_W-1:0] SPB_N = ARX_CNT_W'(ARX_SPB_NORMAL);
    localparam logic [ARX_CNT_W-1:0] SPB_D = ARX_CNT_W'(ARX_SPB_DOUBLE);
    localparam logic [ARX_CNT_W-1:0] ONE = ARX_CNT_W'(1);
    localparam logic [ARX_CNT_W-1:0] TWO = ARX_CNT_W'(2);

    // samples per bit and last vote sample for the active mode
    function automatic logic [ARX_CNT_W-1:0] spb(input logic dbl);
        return dbl ? SPB_D : SPB_N;
    endfunction : spb

    function automatic logic [ARX_CNT_W-1:0] vote_last(input logic dbl);
        return (dbl ? SF_D : SF_N) + TWO;
    endfunction : vote_last

    logic [ARX_SYNC_STAGES-1:0] sync_q;
    logic line_s;
    logic dbl_q;
    logic [3:0] nbits_q;
    arx_state_e state_q;
    logic [ARX_CNT_W-1:0] cnt_q;
    logic [3:0] bit_q;
    logic [DBITS-1:0] shift_q;
    logic in_vote;
    logic vote_done;
    logic bit_end;
    arx_sample_if sif ();

    // two flops before anything looks at the pin
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sync_q <= {ARX_SYNC_STAGES{ARX_LINE_IDLE}};
        end else begin
            sync_q <= {sync_q[ARX_SYNC_STAGES-2:0], RXD};
        end
    end
    assign line_s = sync_q[ARX_SYNC_STAGES-1];

    // mode is latched per frame so a mid-frame change cannot skew timing
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            dbl_q <= 1'b0;
            nbits_q <= 4'h0;
        end else if (state_q == ARX_IDLE) begin
            dbl_q <= (RECEIVE_SPEED_SELECT == ARX_MODE_DOUBLE);
            nbits_q <= FRAME_BITS;
        end
    end

    // vote window covers samples SF..SF+2 of each bit
    // late window start buys slow-side margin, early end buys fast-side margin
    assign in_vote = (cnt_q >= vote_last(dbl_q) - TWO) && (cnt_q <= vote_last(dbl_q));
    assign vote_done = SAMPLE_TICK && (cnt_q == vote_last(dbl_q));
    assign bit_end = SAMPLE_TICK && (cnt_q == spb(dbl_q));

    assign sif.line = line_s;
    assign sif.tick = SAMPLE_TICK && in_vote;
    assign sif.clr = (state_q == ARX_IDLE) || bit_end;

    arx_voter u_voter (
        .clk(CLOCK),
        .rst(RST),
        .sif(sif)
    );

    // frame sequencer
    always_ff @(posedge CLOCK) begin
        if (RST || !RX_ENABLE) begin
            state_q <= ARX_IDLE;
            cnt_q <= ONE;
            bit_q <= 4'h0;
        end else begin
            case (state_q)
                ARX_IDLE: begin
                    // first low sample counts as sample 1
                    if (SAMPLE_TICK && line_s == 1'b0) begin
                        state_q <= ARX_START;
                        cnt_q <= TWO;
                    end
                end
                ARX_START: begin
                    if (SAMPLE_TICK) begin
                        cnt_q <= cnt_q + ONE;
                    end
                    if (vote_done) begin
                        // votes hold ones for high samples; include current one
                        if ((sif.votes[1] & sif.votes[0]) | (sif.votes[1] & line_s)
                            | (sif.votes[0] & line_s)) begin
                            state_q <= ARX_IDLE;
                        end
                    end
                    if (bit_end) begin
                        state_q <= ARX_DATA;
                        cnt_q <= ONE;
                        bit_q <= 4'h0;
                    end
                end
                ARX_DATA: begin
                    if (SAMPLE_TICK) begin
                        cnt_q <= cnt_q + ONE;
                    end
                    if (bit_end) begin
                        cnt_q <= ONE;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q + 4'h1 == nbits_q) begin
                            state_q <= ARX_STOP;
                        end
                    end
                end
                ARX_STOP: begin
                    if (SAMPLE_TICK) begin
                        cnt_q <= cnt_q + ONE;
                    end
                    // rest of the stop bit is not waited for
                    if (vote_done) begin
                        state_q <= ARX_IDLE;
                        cnt_q <= ONE;
                    end
                end
                default: begin
                    state_q <= ARX_IDLE;
                end
            endcase
        end
    end

    // data bits shift in lsb first; parity lands in the top used bit
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            shift_q <= '0;
        end else if (state_q == ARX_DATA && bit_end) begin
            shift_q <= {sif.level, shift_q[DBITS-1:1]};
        end
    end

    // result outputs; third stop sample voted with the two held
    logic stop_level;
    assign stop_level = (sif.votes[1] & sif.votes[0]) | (sif.votes[1] & line_s)
        | (sif.votes[0] & line_s);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            RX_DATA <= '0;
            RX_VALID <= 1'b0;
            FRAME_ERROR <= 1'b0;
        end else begin
            RX_VALID <= 1'b0;
            if (state_q == ARX_STOP && vote_done && RX_ENABLE) begin
                RX_DATA <= shift_q >> (DBITS - int'(nbits_q));
                RX_VALID <= 1'b1;
                FRAME_ERROR <= ~stop_level;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            START_REJECT <= 1'b0;
            RX_BUSY <= 1'b0;
        end else begin
            // disable aborts at once, so a pending reject is dropped too
            START_REJECT <= (state_q == ARX_START) && vote_done && stop_level && RX_ENABLE;
            RX_BUSY <= (state_q != ARX_IDLE);
        end
    end
endmodule : arx_rx_recovery
`default_nettype wire

/* File: dv/arx_checker.sv */
// checker: port-level timing assertions for the receive recovery block
`timescale 1ns/1ps
`default_nettype none
module arx_checker #(
    parameter int DBITS = 9
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // inputs
    input wire logic RX_ENABLE,
    input wire logic SAMPLE_TICK,
    // results
    input wire logic [DBITS-1:0] RX_DATA,
    input wire logic RX_VALID,
    input wire logic FRAME_ERROR,
    input wire logic START_REJECT,
    input wire logic RX_BUSY
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    valid_pulse_a: assert property (RX_VALID |=> !RX_VALID)
        else $error("frame done pulse too long");
    reject_pulse_a: assert property (START_REJECT |=> !START_REJECT)
        else $error("reject pulse too long");
    reject_only_a: assert property (!(RX_VALID && START_REJECT))
        else $error("reject and frame done together");
    valid_tick_a: assert property (RX_VALID |-> $past(SAMPLE_TICK))
        else $error("frame done not after a tick");
    reject_tick_a: assert property (START_REJECT |-> $past(SAMPLE_TICK))
        else $error("reject not after a tick");
    valid_busy_a: assert property (RX_VALID |-> $past(RX_BUSY, 3))
        else $error("frame done without busy frame");
    result_hold_a: assert property ((RX_ENABLE && $past(RX_ENABLE) && !RX_VALID)
        |-> ($stable(RX_DATA) && $stable(FRAME_ERROR))) else $error("result moved alone");
    off_quiet_a: assert property (!RX_ENABLE |=> (!RX_VALID && !START_REJECT))
        else $error("output while disabled");
    off_idle_a: assert property (!RX_ENABLE [*3] |-> !RX_BUSY)
        else $error("busy while disabled");
endmodule : arx_checker
bind arx_rx_recovery arx_checker #(.DBITS(DBITS)) u_chk (.CLOCK(CLOCK), .RST(RST),
    .RX_ENABLE(RX_ENABLE), .SAMPLE_TICK(SAMPLE_TICK), .RX_DATA(RX_DATA),
    .RX_VALID(RX_VALID), .FRAME_ERROR(FRAME_ERROR), .START_REJECT(START_REJECT),
    .RX_BUSY(RX_BUSY));
`default_nettype wire

/* File: dv/arx_tx_model.sv */
// partner: asynchronous transmitter paced by the receiver's sample tick
`timescale 1ns/1ps
`default_nettype none
module arx_tx_model (
    // clock and tick
    input wire logic clk,
    input wire logic tick,
    // serial line, idle high
    output logic txd
);
    initial txd = 1'b1;
    // changes land just after a tick, so the receiver sees them one tick later
    task automatic tk();
        do @(posedge clk); while (tick !== 1'b1);
        #1;
    endtask : tk
    task automatic hold(input logic lvl, input int n);
        txd = lvl;
        repeat (n) tk();
    endtask : hold
    task automatic frame(input logic [9:0] v, input int d, input logic stp, input int spb,
        input int st);
        tk();
        hold(1'b0, spb);
        for (int b = 0; b < d; b++) hold(v[b], spb);
        hold(stp, st);
        // a low stop needs idle time before the next start edge
        if (!stp) hold(1'b1, spb);
    endtask : frame
endmodule : arx_tx_model
`default_nettype wire

/* File: dv/async_rx_clock_data_recovery_test.sv */
// testbench: random frames in every speed against a queue model
`timescale 1ns/1ps
`default_nettype none
module async_rx_clock_data_recovery_test;
    import arx_pkg::*;
    localparam int DBITS = 9;
    logic clock, rst, rx_enable, sample_tick, rxd, rx_valid, frame_error, start_reject, rx_busy;
    logic [1:0] speed;
    logic [3:0] frame_bits;
    logic [DBITS-1:0] rx_data;
    logic [DBITS:0] exp_q[$];
    int n_mismatch = 0;
    int n_tests = 0;
    int n_reject = 0;
    int tcnt = 0;
    int seed = 32'h510fce42;
    arx_rx_recovery #(.DBITS(DBITS)) dut (.CLOCK(clock), .RST(rst), .RX_ENABLE(rx_enable),
        .RECEIVE_SPEED_SELECT(speed), .FRAME_BITS(frame_bits), .SAMPLE_TICK(sample_tick),
        .RXD(rxd), .RX_DATA(rx_data), .RX_VALID(rx_valid), .FRAME_ERROR(frame_error),
        .START_REJECT(start_reject), .RX_BUSY(rx_busy));
    arx_tx_model tx (.clk(clock), .tick(sample_tick), .txd(rxd));
    task automatic check(input logic [DBITS:0] seen, input logic [DBITS:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        #1 sample_tick = (tcnt == 3);
        tcnt = (tcnt + 1) % 4;
    end
    // bits above the frame size are masked off and left unchecked
    always @(posedge clock) begin
        if (rx_valid === 1'b1) check({frame_error, rx_data & DBITS'((1 << frame_bits) - 1)},
            exp_q.size() ? exp_q.pop_front() : 'x);
        if (start_reject === 1'b1) n_reject++;
    end
    initial begin
        logic [DBITS-1:0] v;
        int d;
        int spb;
        rst = 1'b1;
        rx_enable = 1'b1;
        speed = 2'h0;
        frame_bits = 4'h8;
        sample_tick = 1'b0;
        repeat (4) @(posedge clock);
        #1 rst = 1'b0;
        check({rx_valid, rx_busy, start_reject, frame_error}, 'h0);
        for (int m = 0; m < 3; m++) begin
            speed = 2'(m);
            spb = (m == 1) ? ARX_SPB_DOUBLE : ARX_SPB_NORMAL;
            d = 5 + ($unsigned($random(seed)) % 5);
            frame_bits = 4'(d);
            for (int i = 0; i < 4; i++) begin
                v = DBITS'($random(seed));
                exp_q.push_back({1'(i == 2), v & DBITS'((1 << d) - 1)});
                // stop cut to the vote samples, so the next start comes at once
                tx.frame(10'(v), d, i != 2, spb, (i == 3) ? 2 * spb : spb / 2 + 2);
            end
            tx.tk();
            tx.hold(1'b0, 3);
            tx.hold(1'b1, 2 * spb);
            check(DBITS'(n_reject), DBITS'(m + 1));
            check(DBITS'(exp_q.size()), 'h0);
        end
        fork
            tx.frame(10'h0A5, 8, 1'b1, ARX_SPB_NORMAL, ARX_SPB_NORMAL);
            begin
                repeat (100) @(posedge clock);
                #1 rx_enable = 1'b0;
            end
        join
        repeat (8) @(posedge clock);
        #1 rx_enable = 1'b1;
        repeat (20) @(posedge clock);
        check(DBITS'(n_reject), 'h3);
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        end_of_test();
    end
endmodule : async_rx_clock_data_recovery_test
`default_nettype wire
